// *** hdl/ddr_input_capture_frontend.sv ***
// Double-data-rate input capture front end with Wishbone registers and a sample FIFO.
// Assumes all pins are synchronous to clk_i and toggle no faster than half its rate.
//
// What this block does
// RL1: Every line of the 16-bit data bus in word mode, and lines 7 to 0 in byte mode, is captured on both the rising and falling data clock edge.
// RL2: The frame marker taken on the rising data clock edge either clears the FIFO or acts as sync.
// RL3: The frame marker taken on the falling data clock edge is kept as a block parity bit.
// RL4: The source changes the frame marker on the same edges as the data bus.
// RL5: The alignment strobe is taken on the rising edge of the core clock only.
// RL6: In dual sync mode the strobe realigns the divided core clock and empties the FIFO.
// RL7: With the external reference bit set the reference pin is an input, otherwise it is driven.
// RL8: Bit 15 is the top bit in word mode, bit 7 in byte mode, and bit 0 the bottom bit in both.
// RL9: With the reverse bit set the bus bit order is reversed before further use.
`timescale 1ns/1ps
`default_nettype none
module ddr_input_capture_frontend (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] sample_data_pos_i,
  input  wire logic [15:0] sample_data_neg_i,
  input  wire logic        fwd_sample_clock_pos_i,
  input  wire logic        fwd_sample_clock_neg_i,
  input  wire logic        frame_marker_pos_i,
  input  wire logic        frame_marker_neg_i,
  input  wire logic        output_align_strobe_pos_i,
  input  wire logic        output_align_strobe_neg_i,
  input  wire logic        core_conversion_clock_pos_i,
  input  wire logic        core_conversion_clock_neg_i,
  input  wire logic        reference_io_pin_i,
  output logic             reference_io_pin_o,
  output logic             reference_io_pin_oe_o,
  output logic             capture_ready_o,
  output logic             frame_sync_o,
  output logic             frame_parity_o,
  output logic             div_clock_tick_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic                                   dclk_prev;
    logic                                   cclk_prev;
    logic                                   strobe_last;
    logic [ddr_capture_pkg::BUS_W-1:0]      rise_data;
    logic                                   frame_rise;
    logic                                   parity_bit;
    ddr_capture_pkg::if_cfg_t               cfg;
    logic                                   extref;
    logic                                   overflow;
    logic                                   lane_err;
    logic [ddr_capture_pkg::DIV_W-1:0]      div_cnt;
    logic                                   div_tick;
    logic                                   sync_pulse;
    logic                                   fifo_clear;
    logic                                   push;
    ddr_capture_pkg::cap_word_t             push_word;
    logic                                   stage;
    logic                                   ack;
    logic                                   pop_ok;
    logic [31:0]                            dat;
  } fe_st_t;

  fe_st_t st;
  fe_st_t next_st;

  logic                                dclk;
  logic                                cclk;
  logic                                frame_lvl;
  logic                                strobe_lvl;
  logic                                dclk_rise;
  logic                                dclk_fall;
  logic                                cclk_rise;
  logic                                lanes_ok;
  logic [ddr_capture_pkg::BUS_W-1:0]   rev16;
  logic [ddr_capture_pkg::BYTE_W-1:0]  rev8;
  logic [ddr_capture_pkg::BUS_W-1:0]   lane;
  logic                                fifo_ready;
  logic                                fifo_valid;
  ddr_capture_pkg::cap_word_t          fifo_data;
  logic                                req;
  logic                                wr_now;
  logic                                rd_pop;
  logic [31:0]                         status;

  ////////////////////////////////////////////////////////////////////////////////
  // Receivers and bus ordering.

  // A control pair reads high only while its positive half is high and its negative half low; data lanes use the positive half.
  assign dclk       = fwd_sample_clock_pos_i & ~fwd_sample_clock_neg_i;
  assign cclk       = core_conversion_clock_pos_i & ~core_conversion_clock_neg_i;
  assign frame_lvl  = frame_marker_pos_i & ~frame_marker_neg_i;
  assign strobe_lvl = output_align_strobe_pos_i & ~output_align_strobe_neg_i;
  assign lanes_ok   = &(sample_data_pos_i ^ sample_data_neg_i);
  assign dclk_rise  = dclk & ~st.dclk_prev;
  assign dclk_fall  = ~dclk & st.dclk_prev;
  assign cclk_rise  = cclk & ~st.cclk_prev;

  for (genvar i = 0; i < ddr_capture_pkg::BUS_W; i++) begin : g_rev16
    assign rev16[i] = sample_data_pos_i[ddr_capture_pkg::BUS_W-1-i]; // RL9
  end
  for (genvar i = 0; i < ddr_capture_pkg::BYTE_W; i++) begin : g_rev8
    assign rev8[i] = sample_data_pos_i[ddr_capture_pkg::BYTE_W-1-i]; // RL9
  end

  // Byte mode uses only the low lanes, so bit 7 becomes the top bit.
  always_comb begin
    if (st.cfg.byte_mode) begin
      lane = {8'h00, st.cfg.rev_bus ? rev8 : sample_data_pos_i[7:0]}; // RL8
    end else begin
      lane = st.cfg.rev_bus ? rev16 : sample_data_pos_i; // RL8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register access.

  assign req    = wb_cyc_i & wb_stb_i;
  assign wr_now = req & wb_we_i & st.ack & wb_sel_i[0];
  assign rd_pop = req & ~wb_we_i & st.ack & st.pop_ok;

  always_comb begin
    status = 32'h0000_0000;
    status[ddr_capture_pkg::B_ST_VALID]  = fifo_valid;
    status[ddr_capture_pkg::B_ST_OVF]    = st.overflow;
    status[ddr_capture_pkg::B_ST_LANE]   = st.lane_err;
    status[ddr_capture_pkg::B_ST_PARITY] = st.parity_bit;
    status[ddr_capture_pkg::B_ST_FRAME]  = st.frame_rise;
    status[ddr_capture_pkg::B_ST_REF_IN] = reference_io_pin_i;
    status[ddr_capture_pkg::B_ST_EXTREF] = st.extref;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_st = st;
    next_st.dclk_prev  = dclk;
    next_st.cclk_prev  = cclk;
    next_st.sync_pulse = 1'b0;
    next_st.fifo_clear = 1'b0;
    next_st.push       = 1'b0;
    next_st.div_tick   = 1'b0;

    if (dclk_rise) begin
      next_st.rise_data  = lane; // RL1
      next_st.frame_rise = frame_lvl; // RL2
      if (frame_lvl) begin
        if (st.cfg.frame_resets_fifo) begin
          next_st.fifo_clear = 1'b1; // RL2
        end else begin
          next_st.sync_pulse = 1'b1; // RL2
        end
      end
    end
    if (dclk_fall) begin
      next_st.parity_bit = frame_lvl; // RL3
      next_st.push = 1'b1;
      if (st.cfg.byte_mode) begin
        next_st.push_word = {16'h0000, st.rise_data[7:0], lane[7:0]}; // RL1
      end else begin
        next_st.push_word = {lane, st.rise_data}; // RL1
      end
    end

    // Only the core clock edge looks at the strobe; the data clock never does.
    if (cclk_rise) begin
      next_st.strobe_last = strobe_lvl; // RL5
      if (st.cfg.dual_sync && strobe_lvl && !st.strobe_last) begin
        next_st.div_cnt = '0; // RL6
        next_st.fifo_clear = 1'b1; // RL6
      end else begin
        next_st.div_cnt = st.div_cnt + 1'b1;
        next_st.div_tick = (st.div_cnt == ddr_capture_pkg::DIV_LAST);
      end
    end

    // Sticky errors: a new event wins over a clear in the same cycle.
    if (wr_now && wb_adr_i == ddr_capture_pkg::ADR_STATUS) begin
      if (wb_dat_i[ddr_capture_pkg::B_ST_OVF]) begin
        next_st.overflow = 1'b0;
      end
      if (wb_dat_i[ddr_capture_pkg::B_ST_LANE]) begin
        next_st.lane_err = 1'b0;
      end
    end
    if (st.push && !fifo_ready) begin
      next_st.overflow = 1'b1;
    end
    if ((dclk_rise || dclk_fall) && !lanes_ok) begin
      next_st.lane_err = 1'b1;
    end

    if (wr_now && wb_adr_i == ddr_capture_pkg::ADR_IF_CFG) begin
      next_st.cfg.rev_bus           = wb_dat_i[ddr_capture_pkg::B_REV_BUS];
      next_st.cfg.byte_mode         = wb_dat_i[ddr_capture_pkg::B_BYTE_MODE];
      next_st.cfg.dual_sync         = wb_dat_i[ddr_capture_pkg::B_DUAL_SYNC];
      next_st.cfg.frame_resets_fifo = wb_dat_i[ddr_capture_pkg::B_FRAME_RST];
    end
    if (wr_now && wb_adr_i == ddr_capture_pkg::ADR_REF_CFG) begin
      next_st.extref = wb_dat_i[ddr_capture_pkg::B_EXTREF]; // RL7
    end

    // The answer comes two edges after the request so the FIFO head is current.
    next_st.stage = req & ~st.stage & ~st.ack;
    next_st.ack   = req & st.stage;
    if (st.stage) begin
      next_st.pop_ok = 1'b0;
      case (wb_adr_i)
        ddr_capture_pkg::ADR_IF_CFG: begin
          next_st.dat = {28'h0000000, st.cfg.frame_resets_fifo, st.cfg.dual_sync,
                         st.cfg.byte_mode, st.cfg.rev_bus};
        end
        ddr_capture_pkg::ADR_REF_CFG: begin
          next_st.dat = {31'h00000000, st.extref};
        end
        ddr_capture_pkg::ADR_STATUS: begin
          next_st.dat = status;
        end
        ddr_capture_pkg::ADR_DATA: begin
          next_st.dat    = fifo_valid ? fifo_data : 32'h0000_0000;
          next_st.pop_ok = fifo_valid & ~wb_we_i;
        end
        default: begin
          next_st.dat = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.cfg <= ddr_capture_pkg::IF_CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO and outputs.

  // The pins cannot be stalled, so lost words only show up as overflow.
  cap_fifo #(
    .WIDTH (ddr_capture_pkg::FIFO_W),
    .DEPTH (ddr_capture_pkg::FIFO_D)
  ) u_fifo (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .clear_i   (st.fifo_clear),
    .s_valid_i (st.push),
    .s_ready_o (fifo_ready),
    .s_data_i  (st.push_word),
    .m_valid_o (fifo_valid),
    .m_ready_i (rd_pop),
    .m_data_o  (fifo_data)
  );

  assign wb_ack_o              = st.ack;
  assign wb_dat_o              = st.dat;
  assign capture_ready_o       = fifo_ready;
  assign frame_sync_o          = st.sync_pulse;
  assign frame_parity_o        = st.parity_bit;
  assign div_clock_tick_o      = st.div_tick;
  assign reference_io_pin_o    = 1'b1;
  assign reference_io_pin_oe_o = ~st.extref; // RL7

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_rise_capture: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    dclk_rise |=> st.rise_data == $past(lane))
    else $error("rising edge data not captured");

  a_fall_push: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    (dclk_fall && !st.cfg.byte_mode) |=> st.push && st.push_word.fall == $past(lane)
      && st.push_word.rise == $past(st.rise_data))
    else $error("falling edge word not pushed");

  a_frame_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    (dclk_rise && frame_lvl) |=> (st.fifo_clear || frame_sync_o)
      && (frame_sync_o != $past(st.cfg.frame_resets_fifo)))
    else $error("frame marker action wrong");

  a_parity_take: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    dclk_fall |=> frame_parity_o == $past(frame_lvl))
    else $error("parity bit not taken on falling edge");

  a_strobe_core: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
    !cclk_rise |=> $stable(st.strobe_last))
    else $error("strobe sampled off the core clock edge");

  a_align_div: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    (cclk_rise && st.cfg.dual_sync && strobe_lvl && !st.strobe_last)
      |=> st.div_cnt == '0 && st.fifo_clear ##1 !fifo_valid)
    else $error("strobe did not realign divider and FIFO");

  a_ref_drive: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
    (wr_now && wb_adr_i == ddr_capture_pkg::ADR_REF_CFG)
      |=> reference_io_pin_oe_o == !$past(wb_dat_i[ddr_capture_pkg::B_EXTREF]))
    else $error("reference pin direction wrong");

  a_byte_msb: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    (dclk_fall && st.cfg.byte_mode && !st.cfg.rev_bus)
      |=> st.push_word[31:16] == 16'h0000 && st.push_word[7] == $past(sample_data_pos_i[7]))
    else $error("byte mode top bit wrong");

  a_rev_order: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
    (dclk_rise && st.cfg.rev_bus && !st.cfg.byte_mode)
      |=> st.rise_data[0] == $past(sample_data_pos_i[15]))
    else $error("bus order not reversed");

  a_lane_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    ((dclk_rise || dclk_fall) && !lanes_ok) |=> st.lane_err)
    else $error("lane error not flagged");

  a_overflow_set: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    (st.push && !fifo_ready) |=> st.overflow)
    else $error("lost word not flagged as overflow");

  a_sync_only: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    frame_sync_o |-> $past(dclk_rise && frame_lvl && !st.cfg.frame_resets_fifo))
    else $error("frame sync pulse without frame marker");

  a_parity_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    !dclk_fall |=> $stable(frame_parity_o))
    else $error("parity bit changed off the falling edge");

  a_tick_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    (cclk_rise && st.div_cnt == ddr_capture_pkg::DIV_LAST
      && !(st.cfg.dual_sync && strobe_lvl && !st.strobe_last)) |=> div_clock_tick_o)
    else $error("divider wrap gave no tick");

  a_ack_two: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !st.stage && !st.ack)
      |-> ##2 wb_ack_o)
    else $error("register bus answer not two cycles later");

endmodule : ddr_input_capture_frontend
`default_nettype wire

// *** hdl/ddr_capture_pkg.sv ***
// Shared constants and carriers for the double-data-rate input capture front end.
// Assumes a single 200 MHz system clock and a 32-bit classic Wishbone register bus.
package ddr_capture_pkg;

  localparam int unsigned BUS_W  = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_W = 32;
  localparam int unsigned FIFO_D = 16;
  localparam int unsigned DIV_W  = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses, decoded on all four bits 3:0.
  localparam logic [3:0] ADR_IF_CFG = 4'h0;
  localparam logic [3:0] ADR_REF_CFG = 4'h4;
  localparam logic [3:0] ADR_STATUS = 4'h8;
  localparam logic [3:0] ADR_DATA   = 4'hc;

  // Interface configuration fields.
  localparam int unsigned B_REV_BUS    = 0;
  localparam int unsigned B_BYTE_MODE  = 1;
  localparam int unsigned B_DUAL_SYNC  = 2;
  localparam int unsigned B_FRAME_RST  = 3;
  // Reference configuration field.
  localparam int unsigned B_EXTREF     = 0;
  // Status fields.
  localparam int unsigned B_ST_VALID   = 0;
  localparam int unsigned B_ST_OVF     = 1;
  localparam int unsigned B_ST_LANE    = 2;
  localparam int unsigned B_ST_PARITY  = 3;
  localparam int unsigned B_ST_FRAME   = 4;
  localparam int unsigned B_ST_REF_IN  = 5;
  localparam int unsigned B_ST_EXTREF  = 6;

  localparam logic [DIV_W-1:0] DIV_LAST = 2'h3;

  typedef struct packed {
    logic rev_bus;
    logic byte_mode;
    logic dual_sync;
    logic frame_resets_fifo;
  } if_cfg_t;

  localparam if_cfg_t IF_CFG_RESET = '{rev_bus: 1'b0, byte_mode: 1'b0,
                                       dual_sync: 1'b0, frame_resets_fifo: 1'b0};

  typedef struct packed {
    logic [BUS_W-1:0] fall;
    logic [BUS_W-1:0] rise;
  } cap_word_t;

endpackage : ddr_capture_pkg

// *** hdl/cap_mem.sv ***
// Small word memory for the capture FIFO with a registered read port.
// Assumes one clock; read data reflect the address of the previous cycle.
`timescale 1ns/1ps
`default_nettype none
module cap_mem #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : cap_mem
`default_nettype wire

// *** hdl/cap_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides and a clear input.
// Assumes one clock; the drain side sees valid only once registered data are current.
`timescale 1ns/1ps
`default_nettype none
module cap_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clear_i,
  input  wire logic             s_valid_i,
  output logic                  s_ready_o,
  input  wire logic [WIDTH-1:0] s_data_i,
  output logic                  m_valid_o,
  input  wire logic             m_ready_i,
  output logic      [WIDTH-1:0] m_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          fresh;
  } fifo_st_t;

  fifo_st_t st;
  fifo_st_t next_st;
  logic     push;
  logic     pop;

  assign s_ready_o = (st.cnt != DEPTH[AW:0]);
  assign m_valid_o = (st.cnt != '0) && st.fresh;
  assign push      = s_valid_i && s_ready_o;
  assign pop       = m_valid_o && m_ready_i;

  always_comb begin
    next_st = st;
    next_st.fresh = 1'b1;
    if (clear_i) begin
      next_st.wr = '0;
      next_st.rd = '0;
      next_st.cnt = '0;
    end else begin
      // A write into the slot being read leaves the read register stale for a cycle.
      if (push) begin
        next_st.wr = st.wr + 1'b1;
        if (st.wr == st.rd) begin
          next_st.fresh = 1'b0;
        end
      end
      if (pop) begin
        next_st.rd = st.rd + 1'b1;
        next_st.fresh = 1'b0;
      end
      next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  cap_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .clk_i   (clk_i),
    .we_i    (push && !clear_i),
    .waddr_i (st.wr),
    .wdata_i (s_data_i),
    .raddr_i (next_st.rd),
    .rdata_o (m_data_o)
  );

endmodule : cap_fifo
`default_nettype wire

// *** verification/data_source_model.sv ***
// Behavioural baseband source that drives the data, frame, strobe and core clock pins.
// Assumes the capture block samples every pin on clk_i; each level is held at least two cycles.
`timescale 1ns/1ps
`default_nettype none
module data_source_model (
  input  wire logic        clk_i,
  output logic      [15:0] data_pos_o,
  output logic      [15:0] data_neg_o,
  output logic             dclk_pos_o,
  output logic             dclk_neg_o,
  output logic             frame_pos_o,
  output logic             frame_neg_o,
  output logic             strobe_pos_o,
  output logic             strobe_neg_o,
  output logic             cclk_pos_o,
  output logic             cclk_neg_o
);
  logic [15:0] data = 16'h0;
  logic [15:0] skew = 16'h0;
  logic        dclk = 1'b0;
  logic        frame = 1'b0;
  logic        strobe = 1'b0;
  logic        cclk = 1'b0;
  // Negative halves complement the positive ones unless a lane is skewed on purpose.
  assign data_pos_o   = data;
  assign data_neg_o   = ~data ^ skew;
  assign dclk_pos_o   = dclk;
  assign dclk_neg_o   = ~dclk;
  assign frame_pos_o  = frame;
  assign frame_neg_o  = ~frame;
  assign strobe_pos_o = strobe;
  assign strobe_neg_o = ~strobe;
  assign cclk_pos_o   = cclk;
  assign cclk_neg_o   = ~cclk;
  ////////////////////////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold
  // The data clock stands still between words; released lines show the inverse value.
  task automatic send(input logic [15:0] rise, input logic [15:0] fall,
                      input logic fr, input logic ff);
    @(posedge clk_i);
    dclk  <= 1'b1;
    data  <= rise;
    frame <= fr;
    hold(2);
    dclk  <= 1'b0;
    data  <= fall;
    frame <= ff;
    hold(2);
    data  <= ~fall;
    frame <= ~ff;
    hold(2);
  endtask : send
  task automatic core(input logic s);
    @(posedge clk_i);
    cclk   <= 1'b1;
    strobe <= s;
    hold(2);
    cclk <= 1'b0;
    hold(2);
  endtask : core
  task automatic set_strobe(input logic s);
    @(posedge clk_i);
    strobe <= s;
    hold(3);
  endtask : set_strobe
  task automatic fault(input logic [15:0] m);
    @(posedge clk_i);
    skew <= m;
  endtask : fault
endmodule : data_source_model
`default_nettype wire

// *** verification/ddr_input_capture_frontend_tb.sv ***
// Self-checking bench: Wishbone register accesses plus source traffic through the model.
// Assumes the design package is compiled first; only the cycle ceiling ends a wait.
`timescale 1ns/1ps
`default_nettype none
module ddr_input_capture_frontend_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ref_ext = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, q, exp;
  wire logic [31:0] rdat;
  wire logic [15:0] dp, dn;
  wire logic   ack, dcp, dcn, fp, fn, sp, sn, ccp, ccn, ref_o, ref_oe, ready, sync, par, tick;
  wire logic   ref_wire = ref_oe ? ref_o : ref_ext;
  int          failures = 0, check_count = 0, cycles = 0, sync_cnt = 0, tick_cnt = 0, n;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  always #2.5 clk_i = ~clk_i;
  data_source_model src (.clk_i(clk_i), .data_pos_o(dp), .data_neg_o(dn), .dclk_pos_o(dcp),
    .dclk_neg_o(dcn), .frame_pos_o(fp), .frame_neg_o(fn), .strobe_pos_o(sp),
    .strobe_neg_o(sn), .cclk_pos_o(ccp), .cclk_neg_o(ccn));
  ddr_input_capture_frontend DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sample_data_pos_i(dp), .sample_data_neg_i(dn),
    .fwd_sample_clock_pos_i(dcp), .fwd_sample_clock_neg_i(dcn), .frame_marker_pos_i(fp),
    .frame_marker_neg_i(fn), .output_align_strobe_pos_i(sp), .output_align_strobe_neg_i(sn),
    .core_conversion_clock_pos_i(ccp), .core_conversion_clock_neg_i(ccn),
    .reference_io_pin_i(ref_wire), .reference_io_pin_o(ref_o),
    .reference_io_pin_oe_o(ref_oe), .capture_ready_o(ready), .frame_sync_o(sync),
    .frame_parity_o(par), .div_clock_tick_o(tick));
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // A wait that runs out is counted as a mismatch, so a hung design cannot pass.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (sync === 1'b1) sync_cnt <= sync_cnt + 1;
    if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hf, r);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, 4'hf, r);
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] want);
    logic [31:0] r;
    rd(a, r);
    chk(r & m, want);
  endtask : rdc
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15-i];
  endfunction : rev16
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
  endfunction : rev8
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(ddr_capture_pkg::ADR_IF_CFG, ALL, 32'h0);
    rdc(ddr_capture_pkg::ADR_REF_CFG, ALL, 32'h0);
    chk({31'h0, ref_oe}, 32'h1);
    src.send(16'h1234, 16'habcd, 1'b0, 1'b1);
    chk({31'h0, par}, 32'h1);
    rdc(ddr_capture_pkg::ADR_STATUS, ALL, 32'h29);
    rdc(ddr_capture_pkg::ADR_DATA, ALL, 32'habcd1234);
    wr(ddr_capture_pkg::ADR_IF_CFG, 32'h1);
    src.send(16'h0001, 16'h8003, 1'b0, 1'b0);
    chk({31'h0, par}, 32'h0);
    rdc(ddr_capture_pkg::ADR_DATA, ALL, {rev16(16'h8003), rev16(16'h0001)});
    for (int r = 0; r < 2; r++) begin
      wr(ddr_capture_pkg::ADR_IF_CFG, 32'(2 + r));
      src.send(16'hff12, 16'hee81, 1'b0, 1'b0);
      exp = (r == 1) ? {16'h0, rev8(8'h12), rev8(8'h81)} : 32'h00001281;
      rdc(ddr_capture_pkg::ADR_DATA, ALL, exp);
    end
    // Writes without byte lane 0 must leave the configuration alone.
    wb(1'b1, ddr_capture_pkg::ADR_IF_CFG, 32'hf, 4'he, q);
    rdc(ddr_capture_pkg::ADR_IF_CFG, ALL, 32'h3);
    wr(ddr_capture_pkg::ADR_IF_CFG, 32'h0);
    n = sync_cnt;
    src.send(16'h5555, 16'h6666, 1'b1, 1'b0);
    chk(32'(sync_cnt - n), 32'h1);
    rdc(ddr_capture_pkg::ADR_DATA, ALL, 32'h66665555);
    wr(ddr_capture_pkg::ADR_IF_CFG, 32'h8);
    src.send(16'h0001, 16'h0002, 1'b0, 1'b0);
    src.send(16'h0003, 16'h0004, 1'b1, 1'b0);
    chk(32'(sync_cnt - n), 32'h1);
    rdc(ddr_capture_pkg::ADR_DATA, ALL, 32'h00040003);
    rdc(ddr_capture_pkg::ADR_DATA, ALL, 32'h0);
    wr(ddr_capture_pkg::ADR_IF_CFG, 32'h0);
    for (int i = 0; i < 17; i++) src.send(16'(i), 16'(i + 256), 1'b0, 1'b0);
    chk({31'h0, ready}, 32'h0);
    rdc(ddr_capture_pkg::ADR_STATUS, 32'h2, 32'h2);
    for (int i = 0; i < 16; i++) begin
      rdc(ddr_capture_pkg::ADR_DATA, ALL, {16'(i + 256), 16'(i)});
    end
    rdc(ddr_capture_pkg::ADR_DATA, ALL, 32'h0);
    wr(ddr_capture_pkg::ADR_STATUS, 32'h2);
    rdc(ddr_capture_pkg::ADR_STATUS, 32'h3, 32'h0);
    src.fault(16'h0010);
    src.send(16'h0001, 16'h0002, 1'b0, 1'b0);
    src.fault(16'h0000);
    rdc(ddr_capture_pkg::ADR_STATUS, 32'h4, 32'h4);
    wr(ddr_capture_pkg::ADR_STATUS, 32'h4);
    rdc(ddr_capture_pkg::ADR_STATUS, 32'h4, 32'h0);
    rdc(ddr_capture_pkg::ADR_DATA, ALL, 32'h00020001);
    n = tick_cnt;
    repeat (8) src.core(1'b0);
    chk(32'(tick_cnt - n), 32'h2);
    wr(ddr_capture_pkg::ADR_IF_CFG, 32'h4);
    src.send(16'h0007, 16'h0008, 1'b0, 1'b0);
    src.set_strobe(1'b1);
    src.set_strobe(1'b0);
    rdc(ddr_capture_pkg::ADR_DATA, ALL, 32'h00080007);
    src.send(16'h0009, 16'h000a, 1'b0, 1'b0);
    n = tick_cnt;
    src.core(1'b1);
    rdc(ddr_capture_pkg::ADR_DATA, ALL, 32'h0);
    repeat (3) src.core(1'b1);
    chk(32'(tick_cnt - n), 32'h0);
    src.core(1'b1);
    chk(32'(tick_cnt - n), 32'h1);
    wr(ddr_capture_pkg::ADR_REF_CFG, 32'h1);
    chk({31'h0, ref_oe}, 32'h0);
    rdc(ddr_capture_pkg::ADR_STATUS, 32'h60, 32'h40);
    @(posedge clk_i) ref_ext <= 1'b1;
    rdc(ddr_capture_pkg::ADR_STATUS, 32'h60, 32'h60);
    @(posedge clk_i) ref_ext <= 1'b0;
    wr(ddr_capture_pkg::ADR_REF_CFG, 32'h0);
    chk({31'h0, ref_oe}, 32'h1);
    rdc(ddr_capture_pkg::ADR_STATUS, 32'h60, 32'h20);
    close_out();
  end
endmodule : ddr_input_capture_frontend_tb
`default_nettype wire
